// [hdl/compact_isa_alu_decode.sv]
// decode and execute of the five compact register formats behind an AHB-Lite slave
//
// The AHB-Lite slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ns
module compact_isa_alu_decode
(
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp
);

   alu_decode_pkg::state_type r;
   alu_decode_pkg::state_type next_r;

   logic [15:0] ins;
   logic [31:0] a;
   logic [31:0] b;
   logic [31:0] res;
   logic [33:0] sum;
   logic [32:0] sh;
   logic [63:0] prod;
   logic [3:0]  widx;
   logic [3:0]  sidx;
   logic        wr;
   logic        setnz;
   logic        newc;
   logic        newv;
   logic        jump;
   logic        bad;
   logic [2:0]  cyc;
   logic        issue;

   // operand fetch, pc reads ahead of the instruction
   function automatic logic [31:0] operand(input alu_decode_pkg::state_type s,
                                           input logic [3:0] i);
      logic [31:0] p;
      p = s.pc + 32'h4;
      if (i == alu_decode_pkg::PC_INDEX)
         operand = {p[31:1], 1'b0};
      else
         operand = s.gpr[i];
   endfunction

   // {v, c, sum}
   function automatic logic [33:0] addc(input logic [31:0] x,
                                        input logic [31:0] y,
                                        input logic        cin);
      logic [32:0] s;
      s = {1'b0, x} + {1'b0, y} + {32'h0000_0000, cin};
      addc = {(x[31] == y[31]) && (s[31] != x[31]), s};
   endfunction

   // {carry, result}; immediate form treats zero as 32 for right shifts
   function automatic logic [32:0] shifter(input alu_decode_pkg::shift_kind_type k,
                                           input logic [31:0] v,
                                           input logic [7:0]  amt,
                                           input logic        imm,
                                           input logic        cin);
      logic [63:0] t;
      logic [7:0]  n;
      logic [32:0] o;
      n = amt;
      t = 64'h0;
      o = {cin, v};
      if (imm && amt == 8'h00 && k != alu_decode_pkg::shift_left_logical)
         n = 8'h20;
      unique case (k)
         alu_decode_pkg::shift_left_logical:
            if (n > 8'h20)
               o = 33'h0;
            else if (n != 8'h00)
            begin
               t = {32'h0, v} << n;
               o = t[32:0];
            end
         alu_decode_pkg::shift_right_logical:
            if (n > 8'h20)
               o = 33'h0;
            else if (n != 8'h00)
            begin
               t = {v, 32'h0} >> n;
               o = {t[31], t[63:32]};
            end
         alu_decode_pkg::shift_right_arith:
            if (n >= 8'h20)
               o = {33{v[31]}};
            else if (n != 8'h00)
            begin
               t = $signed({v, 32'h0}) >>> n;
               o = {t[31], t[63:32]};
            end
         alu_decode_pkg::rotate_right_reg:
            if (n != 8'h00)
            begin
               t = {v, v} >> n[4:0];
               o = {t[31], t[31:0]};
            end
      endcase
      shifter = o;
   endfunction

   // register readback, taken from the updated state so writes show at once
   function automatic logic [31:0] readback(input alu_decode_pkg::state_type s,
                                            input logic [7:0] ofs);
      logic [31:0] d;
      d = 32'h0;
      if (ofs == alu_decode_pkg::OFS_STATUS)
      begin
         d[alu_decode_pkg::ST_BUSY]    = s.busy_cnt != 3'h0;
         d[alu_decode_pkg::ST_COMPACT] = s.compact_mode;
         d[alu_decode_pkg::ST_UNDEF]   = s.undef;
         d[alu_decode_pkg::ST_DROP]    = s.dropped;
         d[alu_decode_pkg::ST_FLAG_LO +: 4] = s.status_flags_word;
      end
      else if (ofs == alu_decode_pkg::OFS_PC)
         d = s.pc;
      else if (ofs[7:6] == alu_decode_pkg::GPR_WINDOW)
         d = (ofs[5:2] == alu_decode_pkg::PC_INDEX) ? s.pc : s.gpr[ofs[5:2]];
      readback = d;
   endfunction

   always_comb
   begin
      next_r = r;
      ins    = hwdata[15:0];
      a      = 32'h0;
      b      = 32'h0;
      res    = 32'h0;
      sum    = 34'h0;
      sh     = 33'h0;
      prod   = 64'h0;
      widx   = {1'b0, ins[2:0]};
      sidx   = {1'b0, ins[5:3]};
      wr     = 1'b0;
      setnz  = 1'b0;
      newc   = r.status_flags_word.c;
      newv   = r.status_flags_word.v;
      jump   = 1'b0;
      bad    = 1'b0;
      cyc    = alu_decode_pkg::CYC_PLAIN;
      issue  = 1'b0;
      next_r.wr_pend = 1'b0;
      if (r.busy_cnt != 3'h0)
         next_r.busy_cnt = r.busy_cnt - 3'h1;
      // data phase of a write
      if (r.wr_pend)
      begin
         if (r.wr_ofs == alu_decode_pkg::OFS_INSTR)
            issue = 1'b1;
         else if (r.wr_ofs == alu_decode_pkg::OFS_STATUS)
         begin
            next_r.compact_mode = hwdata[alu_decode_pkg::ST_COMPACT];
            next_r.status_flags_word = hwdata[alu_decode_pkg::ST_FLAG_LO +: 4];
            // write one to clear the sticky bits
            if (hwdata[alu_decode_pkg::ST_UNDEF])
               next_r.undef = 1'b0;
            if (hwdata[alu_decode_pkg::ST_DROP])
               next_r.dropped = 1'b0;
         end
         else if (r.wr_ofs == alu_decode_pkg::OFS_PC)
            next_r.pc = hwdata;
         else if (r.wr_ofs[7:6] == alu_decode_pkg::GPR_WINDOW)
         begin
            if (r.wr_ofs[5:2] == alu_decode_pkg::PC_INDEX)
               next_r.pc = hwdata;
            else
               next_r.gpr[r.wr_ofs[5:2]] = hwdata;
         end
      end
      // no issue while the previous one still counts
      if (issue && (r.busy_cnt != 3'h0 || !r.compact_mode))
         next_r.dropped = 1'b1;
      else if (issue)
      begin
         if (ins[15:11] == alu_decode_pkg::FMT_ADDSUB)
         begin
            a = operand(r, sidx);
            b = ins[10] ? {29'h0, ins[8:6]} : operand(r, {1'b0, ins[8:6]});
            sum = ins[9] ? addc(a, ~b, 1'b1) : addc(a, b, 1'b0);
            {newv, newc, res} = sum;
            wr    = 1'b1;
            setnz = 1'b1;
         end
         else if (ins[15:13] == alu_decode_pkg::FMT_SHIFT)
         begin
            sh = shifter(alu_decode_pkg::shift_kind_type'(ins[12:11]),
                         operand(r, sidx), {3'h0, ins[10:6]}, 1'b1, newc);
            {newc, res} = sh;
            wr    = 1'b1;
            setnz = 1'b1;
         end
         else if (ins[15:13] == alu_decode_pkg::FMT_IMM)
         begin
            widx  = {1'b0, ins[10:8]};
            a     = operand(r, widx);
            b     = {24'h0, ins[7:0]};
            setnz = 1'b1;
            wr    = ins[12:11] != 2'h1;
            if (ins[12:11] == 2'h0)
               res = b;
            else
            begin
               sum = (ins[12:11] == 2'h2) ? addc(a, b, 1'b0) : addc(a, ~b, 1'b1);
               {newv, newc, res} = sum;
            end
         end
         else if (ins[15:10] == alu_decode_pkg::FMT_ALU)
         begin
            a     = operand(r, widx);
            b     = operand(r, sidx);
            wr    = 1'b1;
            setnz = 1'b1;
            unique case (alu_decode_pkg::alu_op_type'(ins[9:6]))
               // logical ops keep carry and overflow
               alu_decode_pkg::alu_and:           res = a & b;
               alu_decode_pkg::exclusive_or:      res = a ^ b;
               alu_decode_pkg::inclusive_or:      res = a | b;
               alu_decode_pkg::clear_bits_masked: res = a & ~b;
               alu_decode_pkg::invert_copy:       res = ~b;
               alu_decode_pkg::alu_shift_left,
               alu_decode_pkg::alu_shift_right,
               alu_decode_pkg::alu_shift_arith,
               alu_decode_pkg::alu_rotate:
               begin
                  sh = shifter(ins[9:6] == 4'h7 ? alu_decode_pkg::rotate_right_reg :
                               alu_decode_pkg::shift_kind_type'(ins[7:6] - 2'h2),
                               a, b[7:0], 1'b0, newc);
                  {newc, res} = sh;
                  cyc = alu_decode_pkg::CYC_SHIFT;
               end
               alu_decode_pkg::add_with_carry:
                  {newv, newc, res} = addc(a, b, r.status_flags_word.c);
               alu_decode_pkg::subtract_with_borrow:
                  {newv, newc, res} = addc(a, ~b, r.status_flags_word.c);
               alu_decode_pkg::test_and_flags:
               begin
                  res = a & b;
                  wr  = 1'b0;
               end
               alu_decode_pkg::compare_sub_flags:
               begin
                  {newv, newc, res} = addc(a, ~b, 1'b1);
                  wr = 1'b0;
               end
               alu_decode_pkg::compare_by_addition:
               begin
                  {newv, newc, res} = addc(a, b, 1'b0);
                  wr = 1'b0;
               end
               alu_decode_pkg::zero_minus:
                  {newv, newc, res} = addc(32'h0, ~b, 1'b1);
               alu_decode_pkg::product_op:
               begin
                  prod = a * b;
                  res  = prod[31:0];
                  // early termination on the multiplier's significant bytes
                  if (a[31:8] == 24'h0 || a[31:8] == 24'hFF_FFFF)
                     cyc = 3'h2;
                  else if (a[31:16] == 16'h0 || a[31:16] == 16'hFFFF)
                     cyc = 3'h3;
                  else if (a[31:24] == 8'h0 || a[31:24] == 8'hFF)
                     cyc = 3'h4;
                  else
                     cyc = 3'h5;
               end
            endcase
         end
         else if (ins[15:10] == alu_decode_pkg::FMT_HI)
         begin
            widx = {ins[7], ins[2:0]};
            sidx = {ins[6], ins[5:3]};
            a    = operand(r, widx);
            b    = operand(r, sidx);
            if (ins[9:8] == 2'h3)
            begin
               bad = ins[7];
               jump = !ins[7];
               // target bit 0 picks the state
               next_r.compact_mode = ins[7] ? r.compact_mode : b[0];
               res  = {b[31:1], 1'b0};
               cyc  = alu_decode_pkg::CYC_BRANCH;
            end
            // both selects clear flagged as undefined
            else if (!ins[7] && !ins[6])
               bad = 1'b1;
            else if (ins[9:8] == 2'h1)
            begin
               {newv, newc, res} = addc(a, ~b, 1'b1);
               setnz = 1'b1;
            end
            else
            begin
               res = (ins[9:8] == 2'h0) ? a + b : b;
               wr  = 1'b1;
            end
         end
         else
            bad = 1'b1;
         // commit; an undefined encoding changes nothing but its flag
         if (bad)
            next_r.undef = 1'b1;
         else
         begin
            if (wr && widx == alu_decode_pkg::PC_INDEX)
            begin
               jump = 1'b1;
               res  = {res[31:1], 1'b0};
               cyc  = alu_decode_pkg::CYC_BRANCH;
            end
            else if (wr)
               next_r.gpr[widx] = res;
            next_r.pc = jump ? {res[31:1], 1'b0} : r.pc + 32'h2;
            if (setnz)
               next_r.status_flags_word = '{n: res[31], z: res == 32'h0, c: newc, v: newv};
            next_r.busy_cnt = cyc - 3'h1;
         end
      end
      // address phase; zero wait, the write lands in the following cycle
      if (hsel && htrans[1] && hready)
      begin
         next_r.wr_pend = hwrite;
         next_r.wr_ofs  = haddr[7:0];
         if (!hwrite)
            next_r.hrdata = readback(next_r, haddr[7:0]);
      end
      next_r.hreadyout = 1'b1;
      next_r.hresp     = 1'b0;
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         r              <= '0;
         r.pc           <= alu_decode_pkg::PC_RESET;
         r.compact_mode <= alu_decode_pkg::COMPACT_RESET;
         r.hreadyout    <= 1'b1;
      end
      else
         r <= next_r;
   end

   assign hrdata    = r.hrdata;
   assign hreadyout = r.hreadyout;
   assign hresp     = r.hresp;

endmodule

// [inc/alu_decode_pkg.sv]
// constants and types for the compact instruction decode and execute block
package alu_decode_pkg;

   // register map, byte offsets within the slave window and the offset bits 7:6 value of the gpr window
   localparam logic [7:0] OFS_INSTR  = 8'h00;
   localparam logic [7:0] OFS_STATUS = 8'h04;
   localparam logic [7:0] OFS_PC     = 8'h08;
   localparam logic [1:0] GPR_WINDOW = 2'h1;

   // status word field positions
   localparam int ST_BUSY    = 0;
   localparam int ST_COMPACT = 1;
   localparam int ST_UNDEF   = 2;
   localparam int ST_DROP    = 3;
   localparam int ST_FLAG_LO = 28;

   // reset values
   localparam logic [31:0] PC_RESET      = 32'h0000_0000;
   localparam logic        COMPACT_RESET = 1'b1;

   // cycle counts
   localparam logic [2:0] CYC_PLAIN  = 3'h1;
   localparam logic [2:0] CYC_SHIFT  = 3'h2;
   localparam logic [2:0] CYC_BRANCH = 3'h3;

   // format prefixes and the pc register index
   localparam logic [2:0] FMT_SHIFT  = 3'h0;
   localparam logic [4:0] FMT_ADDSUB = 5'h03;
   localparam logic [2:0] FMT_IMM    = 3'h1;
   localparam logic [5:0] FMT_ALU    = 6'h10;
   localparam logic [5:0] FMT_HI     = 6'h11;
   localparam logic [3:0] PC_INDEX   = 4'hF;

   typedef enum logic [1:0] {
      shift_left_logical  = 2'h0,
      shift_right_logical = 2'h1,
      shift_right_arith   = 2'h2,
      rotate_right_reg    = 2'h3
   } shift_kind_type;

   typedef enum logic [3:0] {
      alu_and              = 4'h0,
      exclusive_or         = 4'h1,
      alu_shift_left       = 4'h2,
      alu_shift_right      = 4'h3,
      alu_shift_arith      = 4'h4,
      add_with_carry       = 4'h5,
      subtract_with_borrow = 4'h6,
      alu_rotate           = 4'h7,
      test_and_flags       = 4'h8,
      zero_minus           = 4'h9,
      compare_sub_flags    = 4'hA,
      compare_by_addition  = 4'hB,
      inclusive_or         = 4'hC,
      product_op           = 4'hD,
      clear_bits_masked    = 4'hE,
      invert_copy          = 4'hF
   } alu_op_type;

   typedef struct packed {
      logic n;
      logic z;
      logic c;
      logic v;
   } flags_type;

   typedef struct packed {
      logic [14:0][31:0] gpr;
      logic [31:0]       pc;
      flags_type         status_flags_word;
      logic              compact_mode;
      logic              undef;
      logic              dropped;
      logic [2:0]        busy_cnt;
      logic              wr_pend;
      logic [7:0]        wr_ofs;
      logic [31:0]       hrdata;
      logic              hreadyout;
      logic              hresp;
   } state_type;

endpackage

// [tb/compact_isa_alu_decode_checker.sv]
// port-level checks of the decode block slave
`timescale 1ns/1ns
module compact_isa_alu_decode_checker
(
   input wire logic        hclk,
   input wire logic        hresetn,
   input wire logic        hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic [2:0]  hsize,
   input wire logic [31:0] hwdata,
   input wire logic        hready,
   input wire logic [31:0] hrdata,
   input wire logic        hreadyout,
   input wire logic        hresp
);
   logic take;
   logic rd;
   assign take = hsel & htrans[1] & hready;
   assign rd   = take & !hwrite;

   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   a_zero_wait: assert property (hreadyout)
      else $error("slave inserted a wait state");
   a_resp_okay: assert property (!hresp)
      else $error("slave answered with an error");
   a_instr_reads: assert property (rd && haddr[7:0] == 8'h00 |=> hrdata == 32'h0)
      else $error("instruction slot read not zero");
   a_gap_zero: assert property (rd && haddr[7:0] inside {[8'h0C:8'h3C]} |=> hrdata == 32'h0)
      else $error("unmapped read not zero");
   a_status_spare: assert property (rd && haddr[7:0] == 8'h04 |=> hrdata[27:4] == 24'h0)
      else $error("spare status bits set");
   a_rdata_holds: assert property (!rd |=> $stable(hrdata))
      else $error("read data moved without a read");
   // raw pc alias must agree with the pc slot
   a_pc_alias: assert property (rd && haddr[7:0] == 8'h7C ##1 rd && haddr[7:0] == 8'h08
      |=> hrdata == $past(hrdata))
      else $error("pc alias and pc slot differ");
   a_gpr_coherent: assert property (take && hwrite && haddr[7:6] == 2'h1 && haddr[7:0] != 8'h7C
      ##1 rd && haddr[7:0] == $past(haddr[7:0]) |=> hrdata == $past(hwdata))
      else $error("register read missed the write before it");
endmodule

// [tb/compact_isa_alu_decode_bench.sv]
// self-checking bench driving the decode block over its bus
`timescale 1ns/1ns
module compact_isa_alu_decode_bench;
   typedef struct packed
   {
      logic [15:0] ins;
      logic [3:0]  rd;
      logic [31:0] pre;
      logic [3:0]  pfl;
      logic [31:0] res;
      logic [3:0]  fl;
      logic        busy;
   } vec_type;
   logic        hclk = 1'b0;
   logic        hresetn = 1'b0;
   logic        hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0]  htrans = 2'h0;
   logic        hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic        hready;
   logic [31:0] hrdata;
   logic        hreadyout;
   logic        hresp;
   int          mismatches = 0;
   int          num_checks = 0;
   int          cycles = 0;
   logic [31:0] q;
   logic [31:0] st;
   vec_type     tbl [32];

   always #10 hclk = ~hclk;
   assign hready = hreadyout;

   compact_isa_alu_decode dut
   (
      .hclk      (hclk),
      .hresetn   (hresetn),
      .hsel      (hsel),
      .haddr     (haddr),
      .htrans    (htrans),
      .hwrite    (hwrite),
      .hsize     (3'h2),
      .hwdata    (hwdata),
      .hready    (hready),
      .hrdata    (hrdata),
      .hreadyout (hreadyout),
      .hresp     (hresp)
   );

   task automatic test_done();
      begin
         $display("checks %0d mismatches %0d", num_checks, mismatches);
         if (mismatches == 0 && num_checks > 0)
            $display("Run complete: PASS");
         else
            $display("Run complete: FAIL");
         $finish;
      end
   endtask

   // generous ceiling, whole run needs a few hundred cycles
   always @(posedge hclk)
   begin
      cycles <= cycles + 1;
      if (cycles == 20000)
      begin
         mismatches++;
         test_done();
      end
   end

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      begin
         num_checks++;
         if (seen !== exp)
         begin
            mismatches++;
            $display("Error %s expected %h seen %h", name, exp, seen);
         end
      end
   endtask

   task automatic wt();
      begin
         do @(posedge hclk); while (hready !== 1'b1);
      end
   endtask

   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r);
      begin
         htrans <= 2'h2;
         hwrite <= w;
         haddr  <= {24'h0, a};
         wt();
         htrans <= 2'h0;
         hwdata <= d;
         wt();
         r = hrdata;
      end
   endtask

   // back-to-back: second address phase overlaps first data phase
   task automatic pair(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic [7:0] b, output logic [31:0] r);
      begin
         htrans <= 2'h2;
         hwrite <= w;
         haddr  <= {24'h0, a};
         wt();
         hwrite <= 1'b0;
         haddr  <= {24'h0, b};
         hwdata <= d;
         wt();
         htrans <= 2'h0;
         wt();
         r = hrdata;
      end
   endtask

   task automatic run(input vec_type v);
      begin
         xfer(1'b1, {2'h0, v.rd, 2'h0} + 8'h40, v.pre, q);
         xfer(1'b1, 8'h04, {v.pfl, 26'h0, 2'h2}, q);
         pair(1'b1, 8'h00, {16'h0, v.ins}, 8'h04, st);
         check("busy", {31'h0, st[0]}, {31'h0, v.busy});
         check("flags", {28'h0, st[31:28]}, {28'h0, v.fl});
         repeat (8) if (st[0]) xfer(1'b0, 8'h04, 32'h0, st);
         xfer(1'b0, {2'h0, v.rd, 2'h0} + 8'h40, 32'h0, q);
         check("result", q, v.res);
      end
   endtask

   initial
   begin
      tbl = '{
         '{16'h0043, 4'h3, 32'h0, 4'h0, 32'h2, 4'h2, 1'b0},
         '{16'h0903, 4'h3, 32'h0, 4'h0, 32'h8000000, 4'h0, 1'b0},
         '{16'h1103, 4'h3, 32'h0, 4'h0, 32'hF8000000, 4'h8, 1'b0},
         '{16'h188B, 4'h3, 32'h0, 4'h0, 32'h7, 4'h0, 1'b0},
         '{16'h1ED3, 4'h3, 32'h0, 4'h0, 32'h0, 4'h6, 1'b0},
         '{16'h1A8B, 4'h3, 32'h0, 4'h0, 32'h1, 4'h2, 1'b0},
         '{16'h1DD3, 4'h3, 32'h0, 4'h0, 32'hA, 4'h0, 1'b0},
         '{16'h24FF, 4'h4, 32'h0, 4'h2, 32'hFF, 4'h2, 1'b0},
         '{16'h2CFF, 4'h4, 32'hFF, 4'h0, 32'hFF, 4'h6, 1'b0},
         '{16'h3401, 4'h4, 32'hFF, 4'h0, 32'h100, 4'h0, 1'b0},
         '{16'h34FF, 4'h4, 32'hFFFFFF01, 4'h0, 32'h0, 4'h6, 1'b0},
         '{16'h3C01, 4'h4, 32'h100, 4'h0, 32'hFF, 4'h2, 1'b0},
         '{16'h400B, 4'h3, 32'hF0F0000C, 4'h0, 32'h4, 4'h0, 1'b0},
         '{16'h404B, 4'h3, 32'h5, 4'h0, 32'h1, 4'h0, 1'b0},
         '{16'h408B, 4'h3, 32'h10000001, 4'h0, 32'h10, 4'h2, 1'b1},
         '{16'h40CB, 4'h3, 32'h1F, 4'h0, 32'h1, 4'h2, 1'b1},
         '{16'h410B, 4'h3, 32'h8000000F, 4'h0, 32'hF8000000, 4'hA, 1'b1},
         '{16'h414B, 4'h3, 32'hFFFFFFFF, 4'h2, 32'h4, 4'h2, 1'b0},
         '{16'h418B, 4'h3, 32'h10, 4'h0, 32'hB, 4'h2, 1'b0},
         '{16'h41CB, 4'h3, 32'h13, 4'h0, 32'h30000001, 4'h0, 1'b1},
         '{16'h420B, 4'h3, 32'hB, 4'h0, 32'hB, 4'h4, 1'b0},
         '{16'h424B, 4'h3, 32'h7, 4'h0, 32'hFFFFFFFC, 4'h8, 1'b0},
         '{16'h428B, 4'h3, 32'h4, 4'h0, 32'h4, 4'h6, 1'b0},
         '{16'h42CB, 4'h3, 32'h7FFFFFFC, 4'h0, 32'h7FFFFFFC, 4'h9, 1'b0},
         '{16'h430B, 4'h3, 32'h3, 4'h0, 32'h7, 4'h0, 1'b0},
         '{16'h434B, 4'h3, 32'h1000000, 4'h0, 32'h4000000, 4'h0, 1'b1},
         '{16'h438B, 4'h3, 32'hF, 4'h0, 32'hB, 4'h0, 1'b0},
         '{16'h43CB, 4'h3, 32'h0, 4'h0, 32'hFFFFFFFB, 4'h8, 1'b0},
         '{16'h4443, 4'h3, 32'h1, 4'h6, 32'h101, 4'h6, 1'b0},
         '{16'h4543, 4'h3, 32'h100, 4'h0, 32'h100, 4'h6, 1'b0},
         '{16'h4643, 4'h3, 32'h0, 4'h9, 32'h100, 4'h9, 1'b0},
         '{16'h4699, 4'h9, 32'h0, 4'h0, 32'h100, 4'h0, 1'b0}
      };
      repeat (20) @(posedge hclk);
      hresetn <= 1'b1;
      hsel    <= 1'b1;
      xfer(1'b1, 8'h40, 32'h80000001, q);
      xfer(1'b1, 8'h44, 32'h4, q);
      xfer(1'b1, 8'h48, 32'h3, q);
      xfer(1'b1, 8'h60, 32'h100, q);
      foreach (tbl[i]) run(tbl[i]);
      xfer(1'b1, 8'h08, 32'h100, q);
      run('{16'h447B, 4'h3, 32'h1, 4'h0, 32'h105, 4'h0, 1'b0});
      run('{16'h4728, 4'h5, 32'h201, 4'h0, 32'h201, 4'h0, 1'b1});
      xfer(1'b0, 8'h08, 32'h0, q);
      check("pc", q, 32'h200);
      check("state", {31'h0, st[1]}, 32'h1);
      run('{16'h4750, 4'hA, 32'h400, 4'h0, 32'h400, 4'h0, 1'b1});
      xfer(1'b0, 8'h08, 32'h0, q);
      check("pc", q, 32'h400);
      check("state", {31'h0, st[1]}, 32'h0);
      // wide state: further instructions must be refused
      pair(1'b1, 8'h00, 32'h2001, 8'h04, st);
      check("dropped", {31'h0, st[3]}, 32'h1);
      xfer(1'b0, 8'h40, 32'h0, q);
      check("r0", q, 32'h80000001);
      // copy into pc drops bit 0, flags stay
      run('{16'h46AF, 4'hF, 32'h0, 4'h0, 32'h200, 4'h0, 1'b1});
      // undefined encodings leave registers alone
      xfer(1'b1, 8'h04, 32'hE, q);
      run('{16'h4403, 4'h3, 32'h55, 4'h0, 32'h55, 4'h0, 1'b0});
      check("undef", {31'h0, st[2]}, 32'h1);
      xfer(1'b1, 8'h04, 32'hE, q);
      run('{16'h4798, 4'h3, 32'h55, 4'h0, 32'h55, 4'h0, 1'b0});
      check("undef", {31'h0, st[2]}, 32'h1);
      pair(1'b1, 8'h58, 32'hA5A5, 8'h58, q);
      check("gpr", q, 32'hA5A5);
      xfer(1'b1, 8'h08, 32'h300, q);
      pair(1'b0, 8'h7C, 32'h0, 8'h08, q);
      check("pc", q, 32'h300);
      xfer(1'b0, 8'h20, 32'h0, q);
      check("gap", q, 32'h0);
      xfer(1'b0, 8'h00, 32'h0, q);
      check("slot", q, 32'h0);
      test_done();
   end
endmodule

bind compact_isa_alu_decode compact_isa_alu_decode_checker chk
(
   .hclk      (hclk),
   .hresetn   (hresetn),
   .hsel      (hsel),
   .haddr     (haddr),
   .htrans    (htrans),
   .hwrite    (hwrite),
   .hsize     (hsize),
   .hwdata    (hwdata),
   .hready    (hready),
   .hrdata    (hrdata),
   .hreadyout (hreadyout),
   .hresp     (hresp)
);
